// [reset_watchdog_pkg.sv]
// constants, carrier types and helpers for the reset source and watchdog block
package reset_watchdog_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned HOLD_TIME_NS = 1000;
  localparam int unsigned HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HOLD_LAST = 5'(HOLD_CYCLES - 1);
  localparam int unsigned LOCO_FREQ_HZ = 15000;

  // watchdog
  localparam int unsigned WDT_WIDTH = 17;
  localparam logic [7:0] WDT_KEY = 8'hac;
  localparam logic [16:0] WDT_FULL = 17'h1ffff;
  localparam logic [2:0] WDT_PERIOD_MAX = 3'h7;

  // boot vector words
  localparam logic [15:0] VECTOR_LO = 16'h0000;
  localparam logic [15:0] VECTOR_HI = 16'h0001;

  // register offsets
  localparam logic [7:0] OFS_SERVICE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_OPTION = 8'h14;
  localparam int SOFT_RESET_BIT = 0;

  // status and mask bit positions
  localparam int ST_PIN = 0;
  localparam int ST_WDT = 1;
  localparam int ST_POR = 2;
  localparam int ST_LVD_RESET = 3;
  localparam int ST_PARITY = 4;
  localparam int ST_ILLEGAL = 5;
  localparam int ST_SOFT = 6;
  localparam int ST_LVD_INT = 7;
  localparam int ST_WDT_INTERVAL = 8;
  localparam int ST_WIDTH = 9;
  localparam logic [8:0] STATUS_RESET = 9'h000;
  localparam logic [8:0] MASK_RESET = 9'h000;

  typedef enum logic [1:0] {LVD_RESET, LVD_INTERRUPT, LVD_DUAL} lvd_mode_type;
  typedef enum logic [1:0] {WIN_OPEN_50, WIN_OPEN_75, WIN_OPEN_100} window_type;

  typedef struct packed {
    logic ext_reset_n;
    logic loco_clk;
    logic por_above_rise;
    logic por_below_fall;
    logic lvd_below_high;
    logic lvd_below_low;
    logic lvd_below;
  } pin_in_type;
  localparam logic [6:0] PIN_IDLE = 7'h40;

  typedef struct packed {
    logic wdt_enable;
    logic [2:0] wdt_period;
    window_type wdt_window;
    lvd_mode_type lvd_mode;
    logic [1:0] lvd_high_sel;
    logic [1:0] lvd_low_sel;
  } option_type;
  localparam logic [11:0] OPTION_RESET = 12'h000;

  // last count before overflow: 2**(10+period) - 1
  function automatic logic [16:0] wdt_limit(logic [2:0] period);
    return WDT_FULL >> (3'(WDT_PERIOD_MAX - period));
  endfunction

  // first count at which the service window is open
  function automatic logic [16:0] window_start(logic [16:0] limit, window_type win);
    logic [16:0] start;
    start = '0;
    case (win)
      WIN_OPEN_50: start = 17'((limit >> 1) + 17'h00001);
      WIN_OPEN_75: start = 17'((limit >> 2) + 17'h00001);
      default: start = '0;
    endcase
    return start;
  endfunction

endpackage

// [pin_sync.sv]
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clean <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          clean[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [reset_source_and_watchdog.sv]
// reset source combiner with windowed watchdog, power and voltage detection
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 17-bit watchdog counts only when option enables
// - watchdog ticks on low-speed oscillator
// - watchdog overflow asserts internal reset
// - single-bit access to service register resets
// - service value other than ACH resets
// - service write with window closed resets
// - seven sources assert the internal reset
// - all sources equal pin reset; vector 0000H
// - power-on hold until rise, reassert below fall
// - low voltage gives reset or interrupt per mode
// - voltage detector mode and levels from options
// - voltage detection stays active in deep sleep
module reset_source_and_watchdog
  import reset_watchdog_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic bit_op,
  output logic [31:0] rdata,
  // pins and comparators
  input wire pin_in_type pin_in,
  // nonvolatile option settings
  input wire option_type option_in,
  // on-chip error sources
  input wire logic parity_error,
  input wire logic illegal_access,
  // outputs
  output logic chip_reset,
  output logic irq,
  output logic [15:0] vector_addr,
  output logic [1:0] lvd_high_sel,
  output logic [1:0] lvd_low_sel
);
  pin_in_type pin_s;
  option_type opt_q;
  logic opt_loaded;
  logic loco_prev;
  logic loco_tick;
  logic [16:0] wdt_count;
  logic [16:0] limit;
  logic window_open;
  logic svc_wr;
  logic svc_good;
  logic svc_bad;
  logic wdt_overflow;
  logic wdt_interval;
  logic wdt_runaway;
  logic por_ok;
  logic lvd_rst_cond;
  logic lvd_int_cond;
  logic lvd_int_prev;
  logic soft_req;
  logic [6:0] src;
  logic any_source;
  logic [4:0] hold_cnt;
  logic [8:0] status;
  logic [8:0] mask;
  logic [8:0] st_set;
  logic [8:0] st_clr;
  logic [8:0] next_status;

  // slow edges must pass the filter before they count
  pin_sync #(
    .WIDTH(7),
    .INIT(PIN_IDLE)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw(pin_in),
    .clean(pin_s)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opt_q <= option_type'(OPTION_RESET);
      opt_loaded <= 1'b0;
    end else if (!opt_loaded) begin
      opt_q <= option_in;
      opt_loaded <= 1'b1;
    end
  end
  assign lvd_high_sel = opt_q.lvd_high_sel;
  assign lvd_low_sel = opt_q.lvd_low_sel;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loco_prev <= 1'b0;
    end else begin
      loco_prev <= pin_s.loco_clk;
    end
  end
  assign loco_tick = pin_s.loco_clk & ~loco_prev;

  assign limit = wdt_limit(opt_q.wdt_period);
  assign window_open = wdt_count >= window_start(limit, opt_q.wdt_window);
  assign svc_wr = wr && (addr == OFS_SERVICE);
  assign svc_good = svc_wr && !bit_op && (wdata[7:0] == WDT_KEY) && window_open;
  assign svc_bad = svc_wr && !svc_good;
  // good service in the same cycle beats overflow
  assign wdt_overflow = opt_q.wdt_enable && loco_tick && (wdt_count == limit) && !svc_good;
  assign wdt_interval = opt_q.wdt_enable && loco_tick &&
                        (wdt_count == 17'(limit - (limit >> 2)));

  always_ff @(posedge clk_sys) begin
    if (rst || chip_reset || svc_good) begin
      wdt_count <= '0;
    end else if (opt_q.wdt_enable && loco_tick) begin
      if (wdt_count == limit) begin
        wdt_count <= '0;
      end else begin
        wdt_count <= 17'(wdt_count + 17'h00001);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdt_runaway <= 1'b0;
    end else begin
      wdt_runaway <= svc_bad || wdt_overflow;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_ok <= 1'b0;
    end else if (pin_s.por_below_fall) begin
      por_ok <= 1'b0;
    end else if (pin_s.por_above_rise) begin
      por_ok <= 1'b1;
    end
  end

  // no sleep state gates these terms
  always_comb begin
    lvd_rst_cond = 1'b0;
    lvd_int_cond = 1'b0;
    case (opt_q.lvd_mode)
      LVD_RESET: lvd_rst_cond = pin_s.lvd_below;
      LVD_INTERRUPT: lvd_int_cond = pin_s.lvd_below;
      LVD_DUAL: begin
        lvd_rst_cond = pin_s.lvd_below_low;
        lvd_int_cond = pin_s.lvd_below_high;
      end
      default: lvd_rst_cond = pin_s.lvd_below;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lvd_int_prev <= 1'b0;
    end else begin
      lvd_int_prev <= lvd_int_cond;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soft_req <= 1'b0;
    end else begin
      soft_req <= wr && (addr == OFS_SOFT_RESET) && wdata[SOFT_RESET_BIT];
    end
  end

  // pin and detectors are relied on to cover low supply
  assign src = {soft_req, illegal_access, parity_error, lvd_rst_cond,
                !por_ok, wdt_runaway, !pin_s.ext_reset_n};
  // unloaded options also hold reset, so nothing runs on stale settings
  assign any_source = (|src) || !opt_loaded;

  // every source takes the same path
  always_ff @(posedge clk_sys) begin
    if (rst || any_source) begin
      chip_reset <= 1'b1;
      hold_cnt <= '0;
    end else if (chip_reset) begin
      if (hold_cnt == HOLD_LAST) begin
        chip_reset <= 1'b0;
      end else begin
        hold_cnt <= 5'(hold_cnt + 5'h01);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vector_addr <= VECTOR_LO;
    end else begin
      vector_addr <= chip_reset ? VECTOR_LO : vector_addr;
    end
  end

  // sticky status, set wins over a write-one clear
  always_comb begin
    st_set = '0;
    st_set[ST_PIN] = !pin_s.ext_reset_n;
    st_set[ST_WDT] = wdt_runaway;
    st_set[ST_POR] = !por_ok;
    st_set[ST_LVD_RESET] = lvd_rst_cond;
    st_set[ST_PARITY] = parity_error;
    st_set[ST_ILLEGAL] = illegal_access;
    st_set[ST_SOFT] = soft_req;
    st_set[ST_LVD_INT] = lvd_int_cond && !lvd_int_prev;
    st_set[ST_WDT_INTERVAL] = wdt_interval;
    st_clr = (wr && (addr == OFS_STATUS)) ? wdata[8:0] : 9'h000;
    next_status = (status & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask <= MASK_RESET;
    end else if (wr && (addr == OFS_MASK)) begin
      mask <= wdata[8:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst || !rd) begin
      rdata <= '0;
    end else begin
      case (addr)
        OFS_STATUS: rdata <= {23'h000000, status};
        OFS_MASK: rdata <= {23'h000000, mask};
        OFS_COUNT: rdata <= {15'h0000, wdt_count};
        OFS_OPTION: rdata <= {20'h00000, opt_q};
        default: rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_wdt_disabled_idle: assert property (
    !opt_q.wdt_enable && opt_loaded && !svc_good |=> $stable(wdt_count))
    else $error("watchdog counted while disabled");

  a_wdt_slow_tick: assert property (
    !loco_tick && !chip_reset && !svc_good |=> $stable(wdt_count))
    else $error("watchdog moved without a slow clock edge");

  a_overflow_reset: assert property (
    wdt_overflow |=> wdt_runaway ##1 chip_reset)
    else $error("overflow did not reset");

  a_bitop_reset: assert property (
    svc_wr && bit_op |=> wdt_runaway ##1 (chip_reset && status[ST_WDT]))
    else $error("bit access to service register not caught");

  a_bad_key_reset: assert property (
    svc_wr && (wdata[7:0] != WDT_KEY) |=> wdt_runaway)
    else $error("wrong service value not caught");

  a_closed_window: assert property (
    svc_wr && !window_open |=> wdt_runaway)
    else $error("service outside window not caught");

  a_good_service: assert property (
    svc_good |=> (wdt_count == 17'h00000) && !wdt_runaway)
    else $error("good service did not clear the counter");

  a_source_reset: assert property (
    (|src) |=> chip_reset [*2])
    else $error("a source did not hold reset");

  a_por_hold: assert property (
    pin_s.por_below_fall |=> !por_ok ##1 chip_reset)
    else $error("supply below fall threshold did not reset");

  // only the rising condition sets the flag; a later clear may leave it low
  a_lvd_irq_mode: assert property (
    opt_q.lvd_mode == LVD_INTERRUPT && pin_s.lvd_below && !lvd_int_prev
      |-> !lvd_rst_cond ##1 status[ST_LVD_INT])
    else $error("voltage interrupt mode misbehaved");

  a_release_hold: assert property (
    $fell(chip_reset) |-> $past(hold_cnt) == HOLD_LAST && !$past(any_source))
    else $error("reset released early");

  a_lvd_reset_mode: assert property (
    opt_q.lvd_mode == LVD_RESET && pin_s.lvd_below |=> chip_reset)
    else $error("voltage reset mode did not reset");

  a_irq_pending: assert property (
    (|(status & mask)) |=> irq)
    else $error("interrupt missing for a pending bit");

  a_irq_quiet: assert property (
    !(|(status & mask)) |=> !irq)
    else $error("interrupt raised with nothing pending");

  a_soft_reset: assert property (
    soft_req |=> chip_reset && status[ST_SOFT])
    else $error("software request did not reset");

  a_option_frozen: assert property (
    opt_loaded |=> $stable(opt_q))
    else $error("options changed after loading");

  a_vector_zero: assert property (
    chip_reset |=> vector_addr == VECTOR_LO)
    else $error("boot vector moved during reset");

  c_overflow: cover property (wdt_overflow ##2 chip_reset);
  c_lvd_dual: cover property (opt_q.lvd_mode == LVD_DUAL && lvd_rst_cond && lvd_int_cond);
  c_service: cover property (svc_good);
  c_lvd_irq: cover property ($rose(status[ST_LVD_INT]) ##1 irq);
  c_soft: cover property (soft_req ##1 chip_reset);
endmodule
`default_nettype wire

// [reset_pins_model.sv]
// partner model: reset pin, slow oscillator and supply comparators
`timescale 1ns/1ps
`default_nettype none
module reset_pins_model
  import reset_watchdog_pkg::*;
#(
  parameter int LOCO_HALF_NS = 200
) (
  // controls from the bench
  input wire logic pin_low,
  input wire logic loco_run,
  input wire logic supply_ok,
  input wire logic supply_drop,
  input wire logic volt_low,
  // pins toward the block
  output var pin_in_type pins
);
  logic loco = 1'b0;

  // slow clock
  // held low between runs so the count can only move when asked
  always begin
    #(LOCO_HALF_NS);
    loco = loco_run ? ~loco : 1'b0;
  end

  // supply hold
  // power-on comparator keeps reset until supply_ok declares supply in range; pin and voltage detectors follow pin_low and volt_low
  always_comb begin
    pins = '{ext_reset_n: ~pin_low, loco_clk: loco, por_above_rise: supply_ok,
      por_below_fall: supply_drop, lvd_below_high: volt_low, lvd_below_low: volt_low,
      lvd_below: volt_low};
  end
endmodule
`default_nettype wire

// [tb_reset_source_and_watchdog.sv]
// self-checking bench for the reset source and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import reset_watchdog_pkg::*;
  logic clk_sys, rst, wr, rd, bit_op, parity_error, illegal_access;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got, got2;
  logic pin_low, loco_run, supply_ok, supply_drop, volt_low, chip_reset, irq;
  logic [15:0] vector_addr;
  logic [1:0] hs, ls;
  pin_in_type pins;
  option_type opt;
  int bad_count = 0;
  int total_checks = 0;
  int k;

  reset_pins_model model (.pin_low(pin_low), .loco_run(loco_run), .supply_ok(supply_ok),
    .supply_drop(supply_drop), .volt_low(volt_low), .pins(pins));

  reset_source_and_watchdog DUT (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .bit_op(bit_op), .rdata(rdata), .pin_in(pins), .option_in(opt),
    .parity_error(parity_error), .illegal_access(illegal_access), .chip_reset(chip_reset),
    .irq(irq), .vector_addr(vector_addr), .lvd_high_sel(hs), .lvd_low_sel(ls));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic b);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    bit_op <= b;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    bit_op <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // polls chip_reset until it reaches the level, then compares
  task automatic wait_rst(input logic lvl, input int n);
    for (int i = 0; i < n; i++) begin
      if (chip_reset === lvl) break;
      @(posedge clk_sys);
      #1;
    end
    chk({31'h0, chip_reset}, {31'h0, lvl});
  endtask

  // bad service attempt: expect a watchdog reset and its cause bit
  task automatic trip(input logic [31:0] d, input logic b);
    wr_reg(OFS_SERVICE, d, b);
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 40);
    rd_reg(OFS_STATUS, got);
    chk(got & 32'h2, 32'h2);
    wr_reg(OFS_STATUS, 32'h1ff, 1'b0);
  endtask

  task automatic wait_open();
    loco_run <= 1'b1;
    got = '0;
    for (int i = 0; i < 3000 && got < 32'd512; i++) rd_reg(OFS_COUNT, got);
  endtask

  task automatic t_powerup();
    repeat (40) @(posedge clk_sys);
    #1 chk({31'h0, chip_reset}, 32'h1);
    chk({16'h0, vector_addr}, {16'h0, VECTOR_LO});
    chk({28'h0, hs, ls}, 32'h6);
    supply_ok <= 1'b1;
    wait_rst(1'b0, 60);
    rd_reg(OFS_OPTION, got);
    chk(got, {20'h0, opt});
  endtask

  task automatic t_sources();
    int bits [6] = '{ST_PIN, ST_POR, ST_LVD_RESET, ST_PARITY, ST_ILLEGAL, ST_SOFT};
    for (k = 0; k < 6; k++) begin
      wr_reg(OFS_STATUS, 32'h1ff, 1'b0);
      case (k)
        0: pin_low <= 1'b1;
        1: {supply_ok, supply_drop} <= 2'b01;
        2: volt_low <= 1'b1;
        3: parity_error <= 1'b1;
        4: illegal_access <= 1'b1;
        default: wr_reg(OFS_SOFT_RESET, 32'h1, 1'b0);
      endcase
      wait_rst(1'b1, 10);
      repeat (5) @(posedge clk_sys);
      {pin_low, volt_low, parity_error, illegal_access, supply_drop} <= '0;
      supply_ok <= 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 chk({31'h0, chip_reset}, 32'h1);
      wait_rst(1'b0, 40);
      chk({16'h0, vector_addr}, 32'h0);
      rd_reg(OFS_STATUS, got);
      chk(got >> bits[k] & 32'h1, 32'h1);
    end
  endtask

  task automatic t_irq();
    wr_reg(OFS_STATUS, 32'h1ff, 1'b0);
    parity_error <= 1'b1;
    @(posedge clk_sys);
    parity_error <= 1'b0;
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 40);
    #1 chk({31'h0, irq}, 32'h0);
    wr_reg(OFS_MASK, 32'h1 << ST_PARITY, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, irq}, 32'h1);
    wr_reg(OFS_STATUS, 32'h1 << ST_PARITY, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk({31'h0, irq}, 32'h0);
    rd_reg(8'hfc, got);
    chk(got, 32'h0);
  endtask

  task automatic t_watchdog();
    trip({24'h0, WDT_KEY}, 1'b0);
    rd_reg(OFS_COUNT, got);
    repeat (100) @(posedge clk_sys);
    rd_reg(OFS_COUNT, got2);
    chk(got2, got);
    wait_open();
    wr_reg(OFS_SERVICE, {24'h0, WDT_KEY}, 1'b0);
    rd_reg(OFS_COUNT, got);
    chk({31'h0, got < 32'd4}, 32'h1);
    // about 1000 slow ticks, still short of the 1024-tick limit
    repeat (7800) @(posedge clk_sys);
    #1 chk({31'h0, chip_reset}, 32'h0);
    wait_rst(1'b1, 1200);
    loco_run <= 1'b0;
    wait_rst(1'b0, 40);
    rd_reg(OFS_STATUS, got);
    chk(got & 32'h2, 32'h2);
    wr_reg(OFS_STATUS, 32'h1ff, 1'b0);
    wait_open();
    loco_run <= 1'b0;
    trip({24'h0, WDT_KEY}, 1'b1);
    trip(32'h55, 1'b0);
  endtask

  // mid-run reset with new options
  task automatic reboot(input option_type o);
    @(posedge clk_sys);
    opt <= o;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk({31'h0, chip_reset}, 32'h1);
    wait_rst(1'b0, 60);
    chk({28'h0, hs, ls}, {28'h0, o.lvd_high_sel, o.lvd_low_sel});
    wr_reg(OFS_STATUS, 32'h1ff, 1'b0);
  endtask

  // watchdog off, open window, voltage interrupt then dual mode
  task automatic t_modes();
    option_type o;
    o = opt;
    o.wdt_enable = 1'b0;
    o.wdt_window = WIN_OPEN_100;
    o.lvd_mode = LVD_INTERRUPT;
    o.lvd_high_sel = 2'h3;
    o.lvd_low_sel = 2'h0;
    reboot(o);
    wr_reg(OFS_MASK, 32'h1 << ST_LVD_INT, 1'b0);
    volt_low <= 1'b1;
    repeat (10) @(posedge clk_sys);
    volt_low <= 1'b0;
    #1 chk({31'h0, irq}, 32'h1);
    chk({31'h0, chip_reset}, 32'h0);
    @(posedge clk_sys);
    loco_run <= 1'b1;
    repeat (100) @(posedge clk_sys);
    loco_run <= 1'b0;
    rd_reg(OFS_COUNT, got);
    chk(got, 32'h0);
    wr_reg(OFS_SERVICE, {24'h0, WDT_KEY}, 1'b0);
    repeat (4) @(posedge clk_sys);
    #1 chk({31'h0, chip_reset}, 32'h0);
    trip(32'h55, 1'b0);
    o.lvd_mode = LVD_DUAL;
    o.wdt_window = WIN_OPEN_75;
    reboot(o);
    trip({24'h0, WDT_KEY}, 1'b0);
    volt_low <= 1'b1;
    wait_rst(1'b1, 10);
    repeat (3) @(posedge clk_sys);
    volt_low <= 1'b0;
    wait_rst(1'b0, 40);
    rd_reg(OFS_STATUS, got);
    chk(got & 32'h88, 32'h88);
  endtask

  initial begin
    #(60000 * 50);
    bad_count++;
    complete_run();
  end

  initial begin
    opt = '{wdt_enable: 1'b1, wdt_period: 3'h0, wdt_window: WIN_OPEN_50,
      lvd_mode: LVD_RESET, lvd_high_sel: 2'h1, lvd_low_sel: 2'h2};
    {rst, wr, rd, bit_op, parity_error, illegal_access, addr, wdata} = {1'b1, 45'h0};
    {pin_low, loco_run, supply_ok, supply_drop, volt_low} = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_powerup();
    t_sources();
    t_irq();
    t_watchdog();
    t_modes();
    complete_run();
  end
endmodule
`default_nettype wire
